/* src/tsswr_pkg.sv */
`default_nettype none
package tsswr_pkg;
	// ****************************************************
	// Register map, byte addresses
	// ****************************************************
	localparam logic [7:0] DBG_CTRL_ADDR = 8'h00;
	localparam logic [7:0] AREA_PTR_ADDR = 8'h04;
	localparam logic [7:0] MISC_EN_ADDR = 8'h08;
	localparam logic [7:0] CNT_CFG_ADDR = 8'h0C;
	localparam logic [7:0] CNT_LO_ADDR = 8'h10;
	localparam logic [7:0] CNT_HI_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;
	// Field positions and reset values
	localparam int BR_EN_BIT = 0;
	localparam int BR_ABSENT_BIT = 0;
	localparam int SMP_ABSENT_BIT = 1;
	localparam int CNT_EN_BIT = 0;
	localparam int SMP_EN_BIT = 1;
	localparam int PRED_BIT = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] AREA_RST = 32'h0000_0000;
	// ****************************************************
	// Management area and record layout
	// ****************************************************
	localparam logic [31:0] BR_IDX_OFF = 32'h0000_0004;
	localparam logic [31:0] SMP_IDX_OFF = 32'h0000_0014;
	localparam logic [31:0] BR_REC_SIZE = 32'h0000_000C;
	localparam logic [31:0] SMP_REC_SIZE = 32'h0000_0028;
	localparam logic [3:0] BR_LD_WORDS = 4'h3;
	localparam logic [3:0] SMP_LD_WORDS = 4'h5;
	localparam logic [3:0] BR_REC_WORDS = 4'h3;
	localparam logic [3:0] SMP_REC_WORDS = 4'hA;
	localparam int GPR_COUNT = 8;
	localparam int CNT_WIDTH = 40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {ST_IDLE, ST_LOAD, ST_CHECK, ST_WRITE, ST_UPDATE,
		ST_RELOAD} tsswr_state_t;
endpackage
`default_nettype wire

/* src/tsswr_counter.sv */
`default_nettype none
module tsswr_counter #(
	parameter int WIDTH = 40
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic evt,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [31:0] wdata,
	input wire logic reload,
	input wire logic [WIDTH-1:0] reload_val,
	output logic [WIDTH-1:0] cnt,
	output logic ovf
);
	logic [WIDTH-1:0] cnt_ff;

	// Overflow is the step from all ones back to zero
	assign ovf = run && evt && (&cnt_ff);
	assign cnt = cnt_ff;

	// Reload outranks a software write, which outranks counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= '0;
		end else if (reload) begin
			cnt_ff <= reload_val; // R17 R3
		end else if (wr_lo) begin
			cnt_ff[31:0] <= wdata;
		end else if (wr_hi) begin
			cnt_ff[WIDTH-1:32] <= wdata[WIDTH-33:0];
		end else if (run && evt) begin
			cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

/* src/tsswr_rec_word.sv */
`default_nettype none
module tsswr_rec_word (
	input wire logic is_smp,
	input wire logic [3:0] sel,
	input wire logic [31:0] br_from,
	input wire logic [31:0] br_to,
	input wire logic br_pred,
	input wire logic [319:0] snap,
	output logic [31:0] word
);
	// Branch: source, target, flag word; sample: flags, ip, gprs
	always_comb begin
		word = 32'h0000_0000;
		if (is_smp) begin
			// Past the last sample word the select would leave the snapshot
			if (sel < tsswr_pkg::SMP_REC_WORDS)
				word = snap[32*sel +: 32]; // R20
		end else if (sel == 4'h0) begin
			word = br_from; // R18
		end else if (sel == 4'h1) begin
			word = br_to; // R18
		end else begin
			word[tsswr_pkg::PRED_BIT] = br_pred; // R19
		end
	end
endmodule
`default_nettype wire

/* src/tsswr_top.sv */
// Function
// R1 - While branch trace is on, each taken branch or trap writes a record.
// R2 - Sampling counter overflow writes flags, ip and eight general registers.
// R3 - After the sample record is written, counter reloads and resumes.
// R4 - Entering system management mode disables all recording.
// R5 - Machine check disables recording; reset and init clear recording state.
// R6 - Recording keeps working in real address mode.
// R7 - Two read-only bits report branch trace and sampling absence.
// R8 - Management area address comes from store area pointer register.
// R9 - Branch record written at branch index; twelve bytes each.
// R10 - Software sets branch maximum and doubleword-aligned base.
// R11 - Interrupt when writing the record at branch threshold.
// R12 - Software places thresholds on records well before maximum.
// R13 - Software sets both indexes to their bases first.
// R14 - Sample record written at sample index; forty bytes each.
// R15 - Software sets sample maximum and doubleword-aligned base.
// R16 - Interrupt when writing the record at sample threshold.
// R17 - Full 40-bit reset value loads into the counter.
// R18 - Branch record holds source then target address.
// R19 - Bit 4 of third branch word marks predicted branch.
// R20 - Sample layout: flags at 0, ip at 4, gprs 8 to 24 hex.
// R21 - Stored ip is code segment base plus offset.
// R22 - Logged registers are those at the start of the instruction.
// R23 - Software configures selection and filtering before counter enable.
// R24 - Only the fifth queue counter supports sample recording.
// R25 - Index advances one record; records reaching maximum are dropped.
// R26 - Record written as sequential doublewords before index update.
`default_nettype none
module tsswr_top #(
	parameter logic BRANCH_TRACE_ABSENT = 1'b0,
	parameter logic SAMPLE_STORE_ABSENT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic br_valid,
	output logic br_ready,
	input wire logic [31:0] br_from,
	input wire logic [31:0] br_to,
	input wire logic br_pred,
	input wire logic cnt_evt,
	input wire logic [31:0] flags_register,
	input wire logic [31:0] ip_offset,
	input wire logic [31:0] cs_base,
	input wire logic [255:0] gpr_values,
	input wire logic system_management_mode,
	input wire logic machine_check,
	input wire logic init_pulse,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic perf_monitor_interrupt
);
	// ****************************************************
	// Declarations
	// ****************************************************
	tsswr_pkg::tsswr_state_t st_ff;
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic trace_en_ff, cnt_en_ff, smp_en_ff, smp_pend_ff;
	logic [31:0] area_ff;
	logic is_smp_ff;
	logic [3:0] k_ff;
	logic [31:0] idx_ff, max_ff, thr_ff, rst_lo_ff;
	logic [7:0] rst_hi_ff;
	logic [31:0] fr_ff, to_ff;
	logic pred_ff;
	logic [319:0] snap_ff;
	logic req_ff, we_ff, irq_ff;
	logic [31:0] addr_ff, wd_ff;
	logic wr_go, halt, cnt_ovf, reload;
	logic [39:0] cnt_val;
	logic [31:0] rec_word, rec_size;
	logic [3:0] wstrb_ff, rec_sel;
	logic [3:0] rec_words, ld_words;

	// Field address of word k in the management area
	function automatic logic [31:0] ld_addr(input logic [31:0] base,
		input logic smp, input logic [3:0] k);
		logic [31:0] off;
		off = smp ? tsswr_pkg::SMP_IDX_OFF : tsswr_pkg::BR_IDX_OFF;
		ld_addr = base + off + {26'h0, k, 2'b00};
	endfunction

	// ****************************************************
	// AXI4-Lite slave
	// ****************************************************
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready = !w_got_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;

	// Address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_got_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				// Strobes may change once the data beat is taken
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_got_ff <= 1'b0;
			end
		end
	end

	// Write response; unmapped or read-only words answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= tsswr_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			case (awaddr_ff)
			tsswr_pkg::DBG_CTRL_ADDR, tsswr_pkg::AREA_PTR_ADDR,
			tsswr_pkg::CNT_CFG_ADDR, tsswr_pkg::CNT_LO_ADDR,
			tsswr_pkg::CNT_HI_ADDR: bresp_ff <= tsswr_pkg::RESP_OKAY;
			default: bresp_ff <= tsswr_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read data registered on address acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= tsswr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= tsswr_pkg::RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
			case (s_axi_araddr)
			tsswr_pkg::DBG_CTRL_ADDR:
				rdata_ff[tsswr_pkg::BR_EN_BIT] <= trace_en_ff;
			tsswr_pkg::AREA_PTR_ADDR: rdata_ff <= area_ff;
			tsswr_pkg::MISC_EN_ADDR: begin
				rdata_ff[tsswr_pkg::BR_ABSENT_BIT] <=
					BRANCH_TRACE_ABSENT; // R7
				rdata_ff[tsswr_pkg::SMP_ABSENT_BIT] <=
					SAMPLE_STORE_ABSENT; // R7
			end
			tsswr_pkg::CNT_CFG_ADDR: begin
				rdata_ff[tsswr_pkg::CNT_EN_BIT] <= cnt_en_ff;
				rdata_ff[tsswr_pkg::SMP_EN_BIT] <= smp_en_ff;
			end
			tsswr_pkg::CNT_LO_ADDR: rdata_ff <= cnt_val[31:0];
			tsswr_pkg::CNT_HI_ADDR: rdata_ff[7:0] <= cnt_val[39:32];
			tsswr_pkg::STATUS_ADDR: begin
				rdata_ff[0] <= (st_ff != tsswr_pkg::ST_IDLE);
				rdata_ff[1] <= smp_pend_ff;
				rdata_ff[2] <= system_management_mode;
			end
			default: rresp_ff <= tsswr_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************************
	// Control registers
	// ****************************************************
	// Hardware disables win over a software write in the same cycle.
	// Processor mode is not an input: real address mode records too.
	always_ff @(posedge aclk) begin
		if (!aresetn || init_pulse) begin
			trace_en_ff <= 1'b0; // R5
			smp_en_ff <= 1'b0; // R5
			cnt_en_ff <= 1'b0;
		end else if (system_management_mode || machine_check) begin
			trace_en_ff <= 1'b0; // R4 R5
			smp_en_ff <= 1'b0; // R4 R5
		end else if (wr_go) begin
			if (awaddr_ff == tsswr_pkg::DBG_CTRL_ADDR && wstrb_ff[0])
				trace_en_ff <= wdata_ff[tsswr_pkg::BR_EN_BIT] &&
					!BRANCH_TRACE_ABSENT; // R7
			if (awaddr_ff == tsswr_pkg::CNT_CFG_ADDR && wstrb_ff[0]) begin
				cnt_en_ff <= wdata_ff[tsswr_pkg::CNT_EN_BIT];
				smp_en_ff <= wdata_ff[tsswr_pkg::SMP_EN_BIT] &&
					!SAMPLE_STORE_ABSENT;
			end
		end
	end

	// Store area pointer, full word only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			area_ff <= tsswr_pkg::AREA_RST;
		end else if (wr_go && awaddr_ff == tsswr_pkg::AREA_PTR_ADDR &&
			wstrb_ff == 4'hF) begin
			area_ff <= wdata_ff; // R8
		end
	end

	// ****************************************************
	// Sampling counter
	// ****************************************************
	// Counter stops from overflow until its record is logged or dropped
	assign halt = smp_pend_ff;
	assign reload = (st_ff == tsswr_pkg::ST_RELOAD);

	tsswr_counter #(
		.WIDTH(tsswr_pkg::CNT_WIDTH)
	) u_queue_counter_five (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(cnt_en_ff && !halt),
		.evt(cnt_evt),
		.wr_lo(wr_go && awaddr_ff == tsswr_pkg::CNT_LO_ADDR),
		.wr_hi(wr_go && awaddr_ff == tsswr_pkg::CNT_HI_ADDR),
		.wdata(wdata_ff),
		.reload(reload),
		.reload_val({rst_hi_ff, rst_lo_ff}),
		.cnt(cnt_val),
		.ovf(cnt_ovf)
	);

	// Pending sample with register snapshot taken at overflow
	always_ff @(posedge aclk) begin
		if (!aresetn || init_pulse) begin
			smp_pend_ff <= 1'b0; // R5
			snap_ff <= '0;
		end else if (cnt_ovf && smp_en_ff) begin
			smp_pend_ff <= 1'b1; // R24 R2
			snap_ff <= {gpr_values, cs_base + ip_offset,
				flags_register}; // R21 R22
		end else if (reload || !smp_en_ff) begin
			smp_pend_ff <= 1'b0;
		end
	end

	// ****************************************************
	// Record sequencer
	// ****************************************************
	assign br_ready = (st_ff == tsswr_pkg::ST_IDLE) && !smp_pend_ff &&
		trace_en_ff;
	assign rec_size = is_smp_ff ? tsswr_pkg::SMP_REC_SIZE :
		tsswr_pkg::BR_REC_SIZE;
	assign rec_words = is_smp_ff ? tsswr_pkg::SMP_REC_WORDS :
		tsswr_pkg::BR_REC_WORDS;
	assign ld_words = is_smp_ff ? tsswr_pkg::SMP_LD_WORDS :
		tsswr_pkg::BR_LD_WORDS;
	// While writing, look one word ahead so the next word is ready at ack
	assign rec_sel = (st_ff == tsswr_pkg::ST_WRITE) ? k_ff + 4'h1 : k_ff;

	tsswr_rec_word u_rec_word (
		.is_smp(is_smp_ff),
		.sel(rec_sel),
		.br_from(fr_ff),
		.br_to(to_ff),
		.br_pred(pred_ff),
		.snap(snap_ff),
		.word(rec_word)
	);

	// One doubleword per memory handshake; next one issued at ack
	always_ff @(posedge aclk) begin
		if (!aresetn || init_pulse) begin
			st_ff <= tsswr_pkg::ST_IDLE;
			is_smp_ff <= 1'b0;
			k_ff <= 4'h0;
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			addr_ff <= 32'h0000_0000;
			wd_ff <= 32'h0000_0000;
			idx_ff <= 32'h0000_0000;
			max_ff <= 32'h0000_0000;
			thr_ff <= 32'h0000_0000;
			rst_lo_ff <= 32'h0000_0000;
			rst_hi_ff <= 8'h00;
			fr_ff <= 32'h0000_0000;
			to_ff <= 32'h0000_0000;
			pred_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= 1'b0;
			case (st_ff)
			tsswr_pkg::ST_IDLE: begin
				k_ff <= 4'h0;
				if (smp_pend_ff) begin
					is_smp_ff <= 1'b1;
					st_ff <= tsswr_pkg::ST_LOAD;
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= ld_addr(area_ff, 1'b1, 4'h0); // R8
				end else if (br_valid && br_ready) begin
					is_smp_ff <= 1'b0; // R1
					fr_ff <= br_from;
					to_ff <= br_to;
					pred_ff <= br_pred;
					st_ff <= tsswr_pkg::ST_LOAD;
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= ld_addr(area_ff, 1'b0, 4'h0); // R8
				end
			end
			tsswr_pkg::ST_LOAD: if (mem_ack) begin
				case (k_ff)
				4'h0: idx_ff <= mem_rdata;
				4'h1: max_ff <= mem_rdata;
				4'h2: thr_ff <= mem_rdata;
				4'h3: rst_lo_ff <= mem_rdata;
				default: rst_hi_ff <= mem_rdata[7:0]; // R17
				endcase
				if (k_ff == ld_words - 4'h1) begin
					req_ff <= 1'b0;
					k_ff <= 4'h0;
					st_ff <= tsswr_pkg::ST_CHECK;
				end else begin
					k_ff <= k_ff + 4'h1;
					addr_ff <= ld_addr(area_ff, is_smp_ff, k_ff + 4'h1);
				end
			end
			tsswr_pkg::ST_CHECK: begin
				// Drop a record whose last byte would reach the maximum
				if (idx_ff + rec_size > max_ff) begin
					st_ff <= is_smp_ff ? tsswr_pkg::ST_RELOAD :
						tsswr_pkg::ST_IDLE; // R25
				end else begin
					st_ff <= tsswr_pkg::ST_WRITE;
					req_ff <= 1'b1;
					we_ff <= 1'b1;
					addr_ff <= idx_ff; // R9 R14
					wd_ff <= rec_word;
				end
			end
			tsswr_pkg::ST_WRITE: if (mem_ack) begin
				if (k_ff == rec_words - 4'h1) begin
					// Whole record out, now move the index
					st_ff <= tsswr_pkg::ST_UPDATE; // R26
					addr_ff <= ld_addr(area_ff, is_smp_ff, 4'h0);
					wd_ff <= idx_ff + rec_size; // R25
					irq_ff <= (idx_ff == thr_ff); // R11 R16
				end else begin
					k_ff <= k_ff + 4'h1;
					addr_ff <= addr_ff + 32'h0000_0004; // R26
					wd_ff <= rec_word;
				end
			end
			tsswr_pkg::ST_UPDATE: if (mem_ack) begin
				req_ff <= 1'b0;
				we_ff <= 1'b0;
				st_ff <= is_smp_ff ? tsswr_pkg::ST_RELOAD :
					tsswr_pkg::ST_IDLE;
			end
			tsswr_pkg::ST_RELOAD: begin
				st_ff <= tsswr_pkg::ST_IDLE; // R3
			end
			default: st_ff <= tsswr_pkg::ST_IDLE;
			endcase
		end
	end

	// Memory port comes straight from the sequencer registers
	assign mem_req = req_ff;
	assign mem_we = we_ff;
	assign mem_addr = addr_ff;
	assign mem_wdata = wd_ff;
	assign perf_monitor_interrupt = irq_ff;
endmodule
`default_nettype wire

/* dv/tsswr_mem.sv */
`default_nettype none
// ****
// Memory holding the management area and buffers
// ****
module tsswr_mem (
	input wire logic aclk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [logic [31:0]];
	logic [1:0] wait_ff;
	logic slow_ff;
	initial begin
		{mem_ack, slow_ff, wait_ff} = 4'h0;
		mem_rdata = 32'h0;
	end
	// Prompt and late answers alternate; read data flips outside the
	// ack so a design that samples it early sees garbage
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && wait_ff != 2'h0)
			wait_ff <= wait_ff - 2'h1;
		else if (mem_req && !mem_ack) begin
			mem_ack <= 1'b1;
			slow_ff <= ~slow_ff;
			wait_ff <= slow_ff ? 2'h0 : 2'h2;
			if (mem_we)
				mem[mem_addr] = mem_wdata;
			else
				mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
		end
	end
endmodule
`default_nettype wire

/* dv/tsswr_props.sv */
`default_nettype none
// ****
// Port checker
// ****
module tsswr_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic br_valid,
	input wire logic br_ready,
	input wire logic system_management_mode,
	input wire logic machine_check,
	input wire logic init_pulse,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic perf_monitor_interrupt
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Shutdown causes take effect on the very next cycle
	AST_MGMT_STOP: assert property (system_management_mode |=> !br_ready)
		else $error("branch taken after mode entry");
	AST_MC_STOP: assert property (machine_check |=> !br_ready)
		else $error("branch taken after machine check");
	AST_INIT_STOP: assert property (init_pulse |=> !br_ready)
		else $error("branch taken after init");
	// A taken branch starts with the area reads, one at a time
	AST_TAKE: assert property (br_valid && br_ready |=> mem_req && !mem_we)
		else $error("no area read after branch");
	AST_BUSY: assert property (br_valid && br_ready |=> !br_ready [*3])
		else $error("branch accepted while busy");
	// Requests stand unchanged until acknowledged
	AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req &&
		$stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
		else $error("memory request changed before ack");
	AST_WORD_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned memory word");
	// Interrupt is one pulse right after a record write completes
	AST_IRQ_ONE: assert property (perf_monitor_interrupt |=>
		!perf_monitor_interrupt)
		else $error("interrupt longer than one cycle");
	AST_IRQ_CAUSE: assert property (perf_monitor_interrupt |->
		$past(mem_ack) && $past(mem_we))
		else $error("interrupt without record write");
endmodule
bind tsswr_top tsswr_props i_tsswr_props (.*);
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
`define CHK(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
// ****
// Bench: register master, core stimulus, record checks
// ****
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] AREA = 32'h0000_1000;
	localparam logic [31:0] MGMT [10] = '{
		32'h0000_2000, 32'h0000_2000, 32'h0000_2031,
		32'h0000_200C, 32'h0000_3000, 32'h0000_3000,
		32'h0000_3051, 32'h0000_3000, 32'h1234_5678,
		32'h0000_00A5};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, br_valid, br_ready;
	logic br_pred, cnt_evt, system_management_mode, machine_check, init_pulse;
	logic mem_req, mem_we, mem_ack, perf_monitor_interrupt;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_wdata, s_axi_rdata, br_from, br_to, flags_register;
	logic [31:0] ip_offset, cs_base, mem_addr, mem_wdata, mem_rdata, d, a;
	logic [255:0] gpr_values;
	int n_errors, checks, irq_n, i;
	tsswr_top i_tsswr_top (.*);
	tsswr_mem i_tsswr_mem (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Interrupt pulses last one cycle, so count them per edge
	always @(posedge aclk) begin
		if (perf_monitor_interrupt === 1'b1)
			irq_n++;
	end
	task automatic results();
		$display("Checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Bounds every wait so a hung handshake still ends the run
	task automatic tick(inout int n);
		n++;
		if (n > 400) begin
			n_errors++;
			$display("Error wait limit reached");
			results();
		end
	endtask
	// Handshakes are judged at the falling edge, where the values
	// equal those the next rising edge will sample
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		logic aw_p, w_p, b_p, aw_t, w_t, b_t;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		{aw_p, w_p, b_p} = 3'h7;
		n = 0;
		while (b_p) begin
			@(negedge aclk);
			aw_t = aw_p && s_axi_awready;
			w_t = w_p && s_axi_wready;
			b_t = !aw_p && !w_p && s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			if (b_t)
				s_axi_bready <= 1'b0;
			aw_p = aw_p && !aw_t;
			w_p = w_p && !w_t;
			b_p = !b_t;
			tick(n);
		end
	endtask
	task automatic rd(input logic [7:0] ad);
		logic ar_p, ar_t, r_t;
		int n;
		@(posedge aclk);
		s_axi_araddr <= ad;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		ar_p = 1'b1;
		r_t = 1'b0;
		n = 0;
		while (!r_t) begin
			@(negedge aclk);
			ar_t = ar_p && s_axi_arready;
			r_t = !ar_p && s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			if (r_t)
				s_axi_rready <= 1'b0;
			ar_p = ar_p && !ar_t;
			tick(n);
		end
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
		rd(ad);
		`CHK("read data", e, d)
		`CHK("read resp", tsswr_pkg::RESP_OKAY, r)
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		rd(tsswr_pkg::STATUS_ADDR);
		while (d[1:0] !== 2'h0) begin
			rd(tsswr_pkg::STATUS_ADDR);
			tick(n);
		end
	endtask
	task automatic br_send(input int k);
		logic h;
		int n;
		@(posedge aclk);
		br_valid <= 1'b1;
		br_from <= 32'h100 + 16 * k;
		br_to <= 32'h200 + 16 * k;
		br_pred <= k[0];
		h = 1'b0;
		n = 0;
		while (!h) begin
			@(negedge aclk);
			h = br_ready;
			@(posedge aclk);
			tick(n);
		end
		br_valid <= 1'b0;
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, br_valid, br_pred, cnt_evt, system_management_mode} = 5'h0;
		{machine_check, init_pulse} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{br_from, br_to, flags_register, ip_offset, cs_base} = 160'h0;
		gpr_values = 256'h0;
		for (i = 0; i < 10; i++)
			i_tsswr_mem.mem[AREA + 4 * i] = MGMT[i];
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(tsswr_pkg::DBG_CTRL_ADDR, tsswr_pkg::CTRL_RST);
		rchk(tsswr_pkg::AREA_PTR_ADDR, tsswr_pkg::AREA_RST);
		wr(tsswr_pkg::MISC_EN_ADDR, 32'hFFFF_FFFF);
		`CHK("read-only resp", tsswr_pkg::RESP_SLVERR, r)
		rchk(tsswr_pkg::MISC_EN_ADDR, 32'h0000_0000);
		rd(8'h1C);
		`CHK("unmapped resp", tsswr_pkg::RESP_SLVERR, r)
		// Five branches; the fifth would pass the buffer end
		wr(tsswr_pkg::AREA_PTR_ADDR, AREA);
		wr(tsswr_pkg::DBG_CTRL_ADDR, 32'h0000_0001);
		for (i = 0; i < 5; i++)
			br_send(i);
		wait_idle();
		for (i = 0; i < 4; i++) begin
			a = 32'h0000_2000 + 12 * i;
			`CHK("branch from", 32'h100 + 16 * i, i_tsswr_mem.mem[a])
			`CHK("branch to", 32'h200 + 16 * i, i_tsswr_mem.mem[a + 4])
			`CHK("predicted", i[0], i_tsswr_mem.mem[a + 8][4])
		end
		`CHK("branch index", 32'h0000_2030, i_tsswr_mem.mem[AREA + 4])
		`CHK("overrun", 0, i_tsswr_mem.mem.exists(32'h0000_2030))
		`CHK("branch interrupts", 1, irq_n)
		// Two events from the top of the count give one overflow
		flags_register <= 32'h0000_0246;
		ip_offset <= 32'h0000_1000;
		cs_base <= 32'h0001_0000;
		for (i = 0; i < 8; i++)
			gpr_values[32 * i +: 32] <= 32'hA000_0000 + i;
		wr(tsswr_pkg::CNT_LO_ADDR, 32'hFFFF_FFFE);
		wr(tsswr_pkg::CNT_HI_ADDR, 32'h0000_00FF);
		wr(tsswr_pkg::CNT_CFG_ADDR, 32'h0000_0003);
		@(posedge aclk);
		cnt_evt <= 1'b1;
		repeat (2) @(posedge aclk);
		cnt_evt <= 1'b0;
		wait_idle();
		`CHK("flags", 32'h0000_0246, i_tsswr_mem.mem[32'h0000_3000])
		`CHK("linear ip", 32'h0001_1000, i_tsswr_mem.mem[32'h0000_3004])
		for (i = 0; i < 8; i++) begin
			a = 32'h0000_3008 + 4 * i;
			`CHK("general reg", 32'hA000_0000 + i, i_tsswr_mem.mem[a])
		end
		`CHK("sample index", 32'h0000_3028, i_tsswr_mem.mem[AREA + 20])
		`CHK("sample interrupts", 2, irq_n)
		rchk(tsswr_pkg::CNT_LO_ADDR, 32'h1234_5678);
		rchk(tsswr_pkg::CNT_HI_ADDR, 32'h0000_00A5);
		// Each shutdown cause in turn clears both enables
		for (i = 0; i < 3; i++) begin
			wr(tsswr_pkg::DBG_CTRL_ADDR, 32'h0000_0001);
			wr(tsswr_pkg::CNT_CFG_ADDR, 32'h0000_0003);
			@(posedge aclk);
			system_management_mode <= (i == 0);
			machine_check <= (i == 1);
			init_pulse <= (i == 2);
			@(posedge aclk);
			{system_management_mode, machine_check, init_pulse} <= 3'h0;
			rchk(tsswr_pkg::DBG_CTRL_ADDR, 32'h0000_0000);
			rd(tsswr_pkg::CNT_CFG_ADDR);
			`CHK("sample enable", 1'b0, d[tsswr_pkg::SMP_EN_BIT])
			`CHK("branch ready", 1'b0, br_ready)
		end
		rchk(tsswr_pkg::AREA_PTR_ADDR, AREA);
		results();
	end
endmodule
`default_nettype wire
